// ===== logic/lcimc_top.sv
// Link-change interrupt and miscellaneous control register bank with AXI4-Lite slave
`timescale 1ns/100ps
module lcimc_top #(
    parameter int unsigned PAUSE_CYCLES = lcimc_pkg::PAUSE_OFF_CYC
) (
    input  logic                          aclk,
    input  logic                          aresetn,
    input  logic [lcimc_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  logic                          s_axi_awvalid,
    output logic                          s_axi_awready,
    input  logic [lcimc_pkg::DATA_W-1:0]  s_axi_wdata,
    input  logic [3:0]                    s_axi_wstrb,
    input  logic                          s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  logic                          s_axi_bready,
    input  logic [lcimc_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  logic                          s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [lcimc_pkg::DATA_W-1:0]  s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  logic                          s_axi_rready,
    input  lcimc_pkg::lcimc_link_t        link_state,
    input  logic                          pause_active,
    output logic                          link_irq_n,
    output logic                          irq,
    output logic                          pause_off_req,
    output lcimc_pkg::lcimc_ctrl_t        ctrl
);

    localparam int CNT_W = $clog2(PAUSE_CYCLES + 1);

    // Elaboration checks on values the logic cannot serve
    if (PAUSE_CYCLES < 1) begin
        $error("PAUSE_CYCLES must be at least one");
    end
    if (lcimc_pkg::IDX_W != lcimc_pkg::ADDR_W - 2) begin
        $error("register index must be the word part of the address");
    end
    if (lcimc_pkg::DATA_W != 32) begin
        $error("read data packing needs a 32-bit data bus");
    end
    if (lcimc_pkg::REG_W != 8) begin
        $error("registers are eight bits wide");
    end
    if (lcimc_pkg::FLG_P12 >= lcimc_pkg::REG_W) begin
        $error("link flag position outside the register");
    end
    if (lcimc_pkg::FIBER_LSB + 2 > lcimc_pkg::REG_W) begin
        $error("fiber threshold field outside the register");
    end
    if (lcimc_pkg::LDO_DIS_BIT >= lcimc_pkg::REG_W) begin
        $error("regulator disable bit outside the register");
    end
    if (lcimc_pkg::VLAN_LSB + 6 > lcimc_pkg::REG_W) begin
        $error("default VLAN insert field outside the register");
    end
    if (lcimc_pkg::STAT_PAUSE >= lcimc_pkg::STAT_W) begin
        $error("status bit outside the status field");
    end

    // Register state
    logic [7:0]                        irq_en_q;
    logic [7:0]                        flags_q;
    logic [7:0]                        flags_d;
    logic [7:0]                        pause_en_q;
    logic [1:0]                        fiber_q;
    logic                              ldo_dis_q;
    logic [5:0]                        vlan_q;
    logic [lcimc_pkg::STAT_W-1:0]      stat_q;
    logic [lcimc_pkg::STAT_W-1:0]      mask_q;

    // Write channel state
    logic                              aw_got_q;
    logic                              w_got_q;
    logic [lcimc_pkg::IDX_W-1:0]       widx_q;
    logic [7:0]                        wbyte_q;
    logic                              wlane_q;
    logic                              awready_q;
    logic                              wready_q;
    logic                              bvalid_q;
    logic [1:0]                        bresp_q;

    // Read channel state
    logic                              arready_q;
    logic                              rvalid_q;
    logic [lcimc_pkg::DATA_W-1:0]      rdata_q;
    logic [1:0]                        rresp_q;

    // Link monitor and pause timer
    lcimc_pkg::lcimc_link_t            link_prev_q;
    logic                              primed_q;
    logic [CNT_W-1:0]                  pause_cnt_q;
    logic                              pause_done_q;
    logic                              pause_req_q;
    logic                              link_irq_n_q;
    logic                              irq_q;

    logic                              do_write;
    logic                              wr_en;
    logic                              ar_take;
    logic [lcimc_pkg::IDX_W-1:0]       ridx;
    logic                              rd_hit;
    logic [7:0]                        rd_byte;
    logic                              wr_hit;
    lcimc_pkg::lcimc_link_t            link_chg;
    logic [7:0]                        flag_set;
    logic [7:0]                        flag_clr;
    logic [lcimc_pkg::STAT_W-1:0]      stat_set;
    logic                              pause_hit;
    logic                              pause_run;
    logic                              pause_fire;

    assign do_write = aw_got_q && w_got_q && !bvalid_q;
    assign wr_en    = do_write && wlane_q;
    assign ar_take  = s_axi_arvalid && arready_q;
    assign ridx     = s_axi_araddr[lcimc_pkg::ADDR_W-1:2];

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            awready_q <= 1'b0;
            widx_q    <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
            widx_q    <= s_axi_awaddr[lcimc_pkg::ADDR_W-1:2];
        end else if (do_write) begin
            aw_got_q  <= 1'b0;
        end else if (!aw_got_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    // Write data capture; only byte lane 0 carries register data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_q  <= 1'b0;
            wready_q <= 1'b0;
            wbyte_q  <= 8'h00;
            wlane_q  <= 1'b0;
        end else if (s_axi_wvalid && wready_q) begin
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_got_q  <= 1'b0;
        end else if (!w_got_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // Write decode; unmapped indices answer with an error
    always_comb begin
        unique case (widx_q)
            lcimc_pkg::IDX_IRQ_EN,
            lcimc_pkg::IDX_FLAGS,
            lcimc_pkg::IDX_PAUSE,
            lcimc_pkg::IDX_FIBER,
            lcimc_pkg::IDX_LDO,
            lcimc_pkg::IDX_VLAN,
            lcimc_pkg::IDX_STAT,
            lcimc_pkg::IDX_MASK: wr_hit = 1'b1;
            default:             wr_hit = 1'b0;
        endcase
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= lcimc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? lcimc_pkg::RESP_OKAY : lcimc_pkg::RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Plain control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_en_q   <= lcimc_pkg::RST_IRQ_EN;
            pause_en_q <= lcimc_pkg::RST_PAUSE;
            fiber_q    <= lcimc_pkg::RST_FIBER;
            ldo_dis_q  <= lcimc_pkg::RST_LDO;
            vlan_q     <= lcimc_pkg::RST_VLAN;
            mask_q     <= lcimc_pkg::RST_MASK;
        end else if (wr_en) begin
            unique case (widx_q)
                lcimc_pkg::IDX_IRQ_EN: irq_en_q   <= wbyte_q;
                lcimc_pkg::IDX_PAUSE:  pause_en_q <= wbyte_q;
                lcimc_pkg::IDX_FIBER:  fiber_q    <= wbyte_q[lcimc_pkg::FIBER_LSB +: 2];
                lcimc_pkg::IDX_LDO:    ldo_dis_q  <= wbyte_q[lcimc_pkg::LDO_DIS_BIT];
                lcimc_pkg::IDX_VLAN:   vlan_q     <= wbyte_q[lcimc_pkg::VLAN_LSB +: 6];
                lcimc_pkg::IDX_MASK:   mask_q     <= wbyte_q[lcimc_pkg::STAT_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Link change detection; no change reported before the first sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_prev_q <= '0;
            primed_q    <= 1'b0;
        end else begin
            link_prev_q <= link_state;
            primed_q    <= 1'b1;
        end
    end

    assign link_chg = primed_q ? (link_state ^ link_prev_q) : '0;

    always_comb begin
        flag_set                     = 8'h00;
        flag_set[lcimc_pkg::FLG_P12] = link_chg.p1_analog || link_chg.p2_analog;
        flag_set[lcimc_pkg::FLG_P3]  = link_chg.p3_mii;
        flag_set[lcimc_pkg::FLG_P2]  = link_chg.p2_analog;
        flag_set[lcimc_pkg::FLG_P1]  = link_chg.p1_analog || link_chg.p1_mii;
        flag_clr = (wr_en && widx_q == lcimc_pkg::IDX_FLAGS) ? wbyte_q : 8'h00;
        // Set wins over a clear in the same cycle; bits 6..3 never set
        flags_d  = (flags_q & ~flag_clr) | flag_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q <= lcimc_pkg::RST_FLAGS;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Active-low link interrupt follows enabled flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_irq_n_q <= 1'b1;
        end else begin
            link_irq_n_q <= ~|(flags_q & irq_en_q);
        end
    end

    // Pause-off iteration limit timer; restarts whenever pause or enable drops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_cnt_q  <= '0;
            pause_done_q <= 1'b0;
        end else if (!pause_run) begin
            pause_cnt_q  <= '0;
            pause_done_q <= 1'b0;
        end else if (pause_fire) begin
            pause_done_q <= 1'b1;
        end else if (!pause_done_q) begin
            pause_cnt_q  <= pause_cnt_q + CNT_W'(1);
        end
    end

    assign pause_run  = (|pause_en_q) && pause_active;
    assign pause_hit  = (pause_cnt_q == CNT_W'(PAUSE_CYCLES - 1));
    assign pause_fire = pause_run && !pause_done_q && pause_hit;

    // One-cycle request when the limit expires
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pause_req_q <= 1'b0;
        end else begin
            pause_req_q <= pause_fire;
        end
    end

    // Summary status, cleared by a read; a new event wins over the clear
    always_comb begin
        stat_set                       = '0;
        stat_set[lcimc_pkg::STAT_LINK]  = |flag_set;
        stat_set[lcimc_pkg::STAT_PAUSE] = pause_fire;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= lcimc_pkg::RST_STAT;
        end else if (ar_take && ridx == lcimc_pkg::IDX_STAT) begin
            stat_q <= stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    // Summary interrupt from unmasked status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    // Read decode; reserved bits read zero
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (ridx)
            lcimc_pkg::IDX_IRQ_EN: rd_byte = irq_en_q;
            lcimc_pkg::IDX_FLAGS:  rd_byte = flags_q;
            lcimc_pkg::IDX_PAUSE:  rd_byte = pause_en_q;
            lcimc_pkg::IDX_FIBER:  rd_byte[lcimc_pkg::FIBER_LSB +: 2] = fiber_q;
            lcimc_pkg::IDX_LDO:    rd_byte[lcimc_pkg::LDO_DIS_BIT] = ldo_dis_q;
            lcimc_pkg::IDX_VLAN:   rd_byte[lcimc_pkg::VLAN_LSB +: 6] = vlan_q;
            lcimc_pkg::IDX_STAT:   rd_byte[lcimc_pkg::STAT_W-1:0] = stat_q;
            lcimc_pkg::IDX_MASK:   rd_byte[lcimc_pkg::STAT_W-1:0] = mask_q;
            default:               rd_hit  = 1'b0;
        endcase
    end

    // Read answer captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= lcimc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= {24'h000000, rd_byte};
            rresp_q   <= rd_hit ? lcimc_pkg::RESP_OKAY : lcimc_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q  <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready          = awready_q;
    assign s_axi_wready           = wready_q;
    assign s_axi_bvalid           = bvalid_q;
    assign s_axi_bresp            = bresp_q;
    assign s_axi_arready          = arready_q;
    assign s_axi_rvalid           = rvalid_q;
    assign s_axi_rdata            = rdata_q;
    assign s_axi_rresp            = rresp_q;
    assign link_irq_n             = link_irq_n_q;
    assign irq                    = irq_q;
    assign pause_off_req          = pause_req_q;
    assign ctrl.fiber_p2_high     = fiber_q[1];
    assign ctrl.fiber_p1_high     = fiber_q[0];
    assign ctrl.ldo_disable       = ldo_dis_q;
    assign ctrl.vlan_insert       = vlan_q;

endmodule

// ===== logic/lcimc_pkg.sv
// Constants, register map and carrier types of the link-change interrupt and misc control bank
package lcimc_pkg;

    // Bus geometry; register byte address is four times the index
    localparam int          ADDR_W        = 12;
    localparam int          IDX_W         = 10;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;

    // Register indices
    localparam logic [9:0]  IDX_IRQ_EN    = 10'h0BB;
    localparam logic [9:0]  IDX_FLAGS     = 10'h0BC;
    localparam logic [9:0]  IDX_PAUSE     = 10'h0BD;
    localparam logic [9:0]  IDX_FIBER     = 10'h0C0;
    localparam logic [9:0]  IDX_LDO       = 10'h0C1;
    localparam logic [9:0]  IDX_VLAN      = 10'h0C2;
    localparam logic [9:0]  IDX_STAT      = 10'h0C8;
    localparam logic [9:0]  IDX_MASK      = 10'h0C9;

    // Reset values
    localparam logic [7:0]  RST_IRQ_EN    = 8'h00;
    localparam logic [7:0]  RST_FLAGS     = 8'h00;
    localparam logic [7:0]  RST_PAUSE     = 8'h00;
    localparam logic [1:0]  RST_FIBER     = 2'h0;
    localparam logic        RST_LDO       = 1'b0;
    localparam logic [5:0]  RST_VLAN      = 6'h00;
    localparam logic [1:0]  RST_STAT      = 2'h0;
    localparam logic [1:0]  RST_MASK      = 2'h0;

    // Link-change flag bit positions
    localparam int          FLG_P12       = 7;
    localparam int          FLG_P3        = 2;
    localparam int          FLG_P2        = 1;
    localparam int          FLG_P1        = 0;

    // Field positions of the other registers
    localparam int          FIBER_LSB     = 6;
    localparam int          LDO_DIS_BIT   = 6;
    localparam int          VLAN_LSB      = 0;

    // Summary interrupt status bits
    localparam int          STAT_W        = 2;
    localparam int          STAT_LINK     = 0;
    localparam int          STAT_PAUSE    = 1;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    // Pause-off iteration limit timing
    localparam int unsigned PAUSE_OFF_MS  = 160;
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned PAUSE_OFF_CYC = PAUSE_OFF_MS * (CLK_HZ / 1000);

    typedef struct packed {
        logic p1_analog;
        logic p1_mii;
        logic p2_analog;
        logic p3_mii;
    } lcimc_link_t;

    typedef struct packed {
        logic src1_to_p2;
        logic src1_to_p3;
        logic src2_to_p1;
        logic src2_to_p3;
        logic src3_to_p1;
        logic src3_to_p2;
    } lcimc_vlan_t;

    typedef struct packed {
        logic        fiber_p2_high;
        logic        fiber_p1_high;
        logic        ldo_disable;
        lcimc_vlan_t vlan_insert;
    } lcimc_ctrl_t;

endpackage

// ===== verification/lcimc_top_properties.sv
// Port-level assertions of the link-change interrupt and control bank
`timescale 1ns/100ps
module lcimc_top_properties #(
    parameter int unsigned PAUSE_CYCLES = 8
) (
    input logic                   aclk,
    input logic                   aresetn,
    input logic                   s_axi_awvalid,
    input logic                   s_axi_awready,
    input logic                   s_axi_wvalid,
    input logic                   s_axi_wready,
    input logic [1:0]             s_axi_bresp,
    input logic                   s_axi_bvalid,
    input logic                   s_axi_bready,
    input logic                   s_axi_arvalid,
    input logic                   s_axi_arready,
    input logic [31:0]            s_axi_rdata,
    input logic                   s_axi_rvalid,
    input logic                   s_axi_rready,
    input logic                   pause_active,
    input logic                   link_irq_n,
    input logic                   irq,
    input logic                   pause_off_req,
    input lcimc_pkg::lcimc_ctrl_t ctrl
);
    logic [31:0] act_cnt_q;

    // Consecutive cycles with pause in progress
    always_ff @(posedge aclk) begin
        if (!aresetn || !pause_active) begin
            act_cnt_q <= 32'h0;
        end else if (act_cnt_q != 32'hFFFFFFFF) begin
            act_cnt_q <= act_cnt_q + 32'h1;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response not on time");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during response");
    a_ctrl_by_write: assert property ($changed(ctrl) |-> s_axi_bvalid)
        else $error("control changed without write");
    a_irq_n_release: assert property ($rose(link_irq_n) |-> $past(s_axi_bvalid))
        else $error("link interrupt released without write");
    a_irq_drop: assert property ($fell(irq) |-> $past(s_axi_rvalid) || $past(s_axi_bvalid))
        else $error("summary interrupt dropped without access");
    a_pause_single: assert property (pause_off_req |=> !pause_off_req)
        else $error("pause-off request longer than one cycle");
    a_pause_wait: assert property (pause_off_req |-> act_cnt_q >= PAUSE_CYCLES)
        else $error("pause-off request too early");
endmodule

bind lcimc_top lcimc_top_properties #(.PAUSE_CYCLES(PAUSE_CYCLES)) chk_u (.*);

// ===== verification/lcimc_top_tb.sv
// Self-checking bench of the link-change interrupt and control bank
`timescale 1ns/100ps
module lcimc_top_tb;
    localparam int unsigned PCYC = 8;
    logic                   aclk = 1'b0;
    logic                   aresetn = 1'b0;
    logic [11:0]            s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]             s_axi_wstrb = 4'h0;
    logic [1:0]             s_axi_bresp, s_axi_rresp;
    logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pause_active = 1'b0;
    logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic                   s_axi_rvalid, link_irq_n, irq, pause_off_req;
    lcimc_pkg::lcimc_link_t link_state = 4'h0;
    lcimc_pkg::lcimc_ctrl_t ctrl;
    int                     errors = 0, samples_checked = 0, m[int], k;
    int                     lmap[4] = '{8'h04, 8'h82, 8'h01, 8'h81};
    logic [9:0]             idxs[8] = '{lcimc_pkg::IDX_IRQ_EN, lcimc_pkg::IDX_FLAGS,
        lcimc_pkg::IDX_PAUSE, lcimc_pkg::IDX_FIBER, lcimc_pkg::IDX_LDO, lcimc_pkg::IDX_VLAN,
        lcimc_pkg::IDX_STAT, lcimc_pkg::IDX_MASK};
    logic [3:0]             t;

    lcimc_top #(.PAUSE_CYCLES(PCYC)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_state(link_state),
        .pause_active(pause_active), .link_irq_n(link_irq_n), .irq(irq),
        .pause_off_req(pause_off_req), .ctrl(ctrl));

    always #10 aclk = ~aclk;

    task automatic end_sim();
        $display("Errors %0d, checks %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask

    function automatic int wmask(input logic [9:0] i);
        case (i)
            lcimc_pkg::IDX_IRQ_EN, lcimc_pkg::IDX_PAUSE: return 8'hFF;
            lcimc_pkg::IDX_FIBER: return 8'hC0;
            lcimc_pkg::IDX_LDO:   return 8'h40;
            lcimc_pkg::IDX_VLAN:  return 8'h3F;
            lcimc_pkg::IDX_MASK:  return 8'h03;
            default:              return 8'h00;
        endcase
    endfunction

    // Bits software may set; reserved fields stay at their defaults
    function automatic logic [31:0] legal(input logic [9:0] i);
        case (i)
            lcimc_pkg::IDX_FLAGS: return 32'hFFFFFF87;
            lcimc_pkg::IDX_FIBER, lcimc_pkg::IDX_LDO, lcimc_pkg::IDX_VLAN:
                return 32'hFFFFFF00 | wmask(i);
            default:              return 32'hFFFFFFFF;
        endcase
    endfunction

    task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [3:0] st);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        if (m.exists(i) && st[0]) begin
            if (i == lcimc_pkg::IDX_FLAGS) m[i] = m[i] & ~int'(d[7:0]);
            else if (i != lcimc_pkg::IDX_STAT) m[i] = int'(d[7:0]) & wmask(i);
        end
        chk(32'(s_axi_bresp), 32'(m.exists(i) ? lcimc_pkg::RESP_OKAY : lcimc_pkg::RESP_SLVERR),
            "bresp");
        @(posedge aclk);
    endtask

    task automatic rd(input logic [9:0] i);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, 32'(m.exists(i) ? m[i] : 0), "rdata");
        chk(32'(s_axi_rresp), 32'(m.exists(i) ? lcimc_pkg::RESP_OKAY : lcimc_pkg::RESP_SLVERR),
            "rresp");
        if (i == lcimc_pkg::IDX_STAT) m[i] = 0;
        @(posedge aclk);
    endtask

    // Interrupt pins against the model once settled
    task automatic pins();
        repeat (3) @(posedge aclk);
        chk(32'(link_irq_n), 32'((m[lcimc_pkg::IDX_IRQ_EN] & m[lcimc_pkg::IDX_FLAGS]) == 0),
            "link_irq_n");
        chk(32'(irq), 32'((m[lcimc_pkg::IDX_STAT] & m[lcimc_pkg::IDX_MASK]) != 0), "irq");
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge aclk);
            chk(32'(pause_off_req), 32'h0, "pause_off_req idle");
        end
    endtask

    initial begin
        #400000;
        errors++;
        end_sim();
    end

    initial begin
        void'($urandom(32'hA56E0E63));
        foreach (idxs[j]) m[idxs[j]] = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, random writes, ignored strobe, read-back
        for (int p = 0; p < 3; p++) begin
            foreach (idxs[j]) begin
                rd(idxs[j]);
                wr(idxs[j], $urandom & legal(idxs[j]), (p == 2) ? 4'hE : 4'hF);
                rd(idxs[j]);
            end
            chk(32'(ctrl), 32'(((m[lcimc_pkg::IDX_FIBER] >> 6) << 7) | (m[lcimc_pkg::IDX_LDO]
                & 8'h40) | m[lcimc_pkg::IDX_VLAN]), "ctrl");
            pins();
        end
        wr(10'h0C3, $urandom, 4'hF);
        rd(10'h0C3);
        rd(10'h3FF);
        // Random link changes, enables, masks and clears
        for (int n = 0; n < 20; n++) begin
            wr(lcimc_pkg::IDX_IRQ_EN, $urandom, 4'hF);
            wr(lcimc_pkg::IDX_MASK, $urandom, 4'hF);
            t = $urandom;
            link_state <= link_state ^ t;
            for (int b = 0; b < 4; b++) begin
                if (t[b]) begin
                    m[lcimc_pkg::IDX_FLAGS] |= lmap[b];
                    m[lcimc_pkg::IDX_STAT] |= 1;
                end
            end
            pins();
            rd(lcimc_pkg::IDX_FLAGS);
            rd(lcimc_pkg::IDX_STAT);
            pins();
            wr(lcimc_pkg::IDX_FLAGS, $urandom & legal(lcimc_pkg::IDX_FLAGS), 4'hF);
            pins();
        end
        // Pause-off limit disabled, then enabled
        wr(lcimc_pkg::IDX_PAUSE, 32'h0, 4'hF);
        pause_active <= 1'b1;
        quiet(3 * PCYC);
        pause_active <= 1'b0;
        @(posedge aclk);
        wr(lcimc_pkg::IDX_PAUSE, 1 + $urandom_range(254), 4'hF);
        pause_active <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (pause_off_req !== 1'b1 && k < 40);
        chk(32'(k == PCYC + 1), 32'h1, "pause-off delay");
        m[lcimc_pkg::IDX_STAT] |= 2;
        quiet(3 * PCYC);
        pause_active <= 1'b0;
        wr(lcimc_pkg::IDX_MASK, 32'h3, 4'hF);
        pins();
        rd(lcimc_pkg::IDX_STAT);
        pins();
        end_sim();
    end
endmodule
